// ---- verilog/eye_monitor_result_status_regs.v ----
`timescale 1ns/1ps
`include "eye_monitor_defines.vh"

module eye_monitor_result_status_regs #(
  // result word layout
  parameter CODE_W = `CODE_BITS,
  parameter WORD_W = `WORD_BITS,
  parameter EDGE_COUNT = `EDGE_WORDS,
  parameter ADDR_W = `ADDR_BITS
) (
  // clock and reset
  input wire i_clk,
  input wire i_arst_n,
  // serial control register read port
  input wire i_rd_en,
  input wire [ADDR_W-1:0] i_rd_addr,
  output reg [WORD_W-1:0] o_rd_data,
  // host start control
  input wire i_monitor_start_request,
  input wire i_shape_scan_select,
  // monitor engine
  input wire i_scan_done,
  input wire i_scan_partial,
  input wire [EDGE_COUNT*CODE_W-1:0] i_voltage_codes,
  input wire [EDGE_COUNT*CODE_W-1:0] i_phase_codes,
  input wire [WORD_W-1:0] i_segment_bytes,
  input wire i_cdr_locked,
  input wire i_sleep,
  // engine control and state
  output reg o_engine_run,
  output reg [1:0] o_monitor_state_field
);

  // ****************************************
  // state codes
  // ****************************************
  // the state register doubles as the reported field, so codes equal field codes
  localparam [1:0] S_IDLE = `ST_IDLE;
  localparam [1:0] S_BUSY = `ST_BUSY;
  localparam [1:0] S_DONE = `ST_DONE;
  localparam [1:0] S_ABORT = `ST_ABORT;

  // ****************************************
  // decode helpers
  // ****************************************
  // either condition stops a running scan and refuses a new one
  function is_fault;
    input locked;
    input asleep;
    begin
      is_fault = !locked || asleep;
    end
  endfunction

  // edge words sit at four consecutive word addresses
  function is_edge_addr;
    input [ADDR_W-1:0] addr;
    begin
      is_edge_addr = (addr >= `ADDR_LEFT_EDGE) && (addr <= `ADDR_BOTTOM_EDGE);
    end
  endfunction

  // slot of an edge word, counted from the left edge address
  function [1:0] edge_slot;
    input [ADDR_W-1:0] addr;
    reg [ADDR_W-1:0] diff;
    begin
      diff = addr - `ADDR_LEFT_EDGE;
      edge_slot = diff[1:0];
    end
  endfunction

  // status word: state in the low bits, full/partial flag above, rest zero
  function [WORD_W-1:0] status_word;
    input partial;
    input [1:0] state;
    begin
      status_word = `ZERO16;
      status_word[`PARTIAL_BIT] = partial; // [RULE4]
      status_word[`STATE_MSB:`STATE_LSB] = state; // [RULE6] [RULE11]
    end
  endfunction

  // ****************************************
  // internal state
  // ****************************************
  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg partial_reg;
  reg partial_next;
  reg [WORD_W-1:0] size_reg;
  reg [WORD_W-1:0] rd_next;
  reg [WORD_W-1:0] edge_sel;
  wire fault;
  wire capture;
  wire [EDGE_COUNT*WORD_W-1:0] edge_words;

  assign fault = is_fault(i_cdr_locked, i_sleep); // [RULE8]
  // fault beats done in one cycle: an aborted scan leaves the older results readable
  assign capture = (state_reg == S_BUSY) && !fault && i_scan_done;

  // ****************************************
  // handshake state machine
  // ****************************************
  always @* begin
    state_next = state_reg;
    case (state_reg)
      S_IDLE: begin
        if (i_monitor_start_request) begin // [RULE7] [RULE10]
          // abort right away when a fault already holds at the request
          state_next = fault ? S_ABORT : S_BUSY; // [RULE8]
        end
      end
      S_BUSY: begin
        if (fault) begin
          state_next = S_ABORT; // [RULE8]
        end else if (i_scan_done) begin
          state_next = S_DONE; // [RULE10]
        end
      end
      S_DONE, S_ABORT: begin
        // result held until the host drops start
        if (!i_monitor_start_request) begin
          state_next = S_IDLE; // [RULE7] [RULE10]
        end
      end
      default: begin
        state_next = S_IDLE;
      end
    endcase
  end

  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_reg <= S_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // ****************************************
  // registered outputs
  // ****************************************
  // taken from the next state so the pins change on the same edge as state_reg
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_monitor_state_field <= S_IDLE;
      o_engine_run <= 1'h0;
    end else begin
      o_monitor_state_field <= state_next; // [RULE6]
      o_engine_run <= (state_next == S_BUSY); // [RULE10]
    end
  end

  // ****************************************
  // result capture
  // ****************************************
  // shape scan leaves bit 8 undefined; zero is reported there so reads stay stable
  always @* begin
    partial_next = partial_reg;
    if (capture) begin
      partial_next = i_shape_scan_select ? 1'h0 : i_scan_partial; // [RULE4] [RULE5]
    end
  end

  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      partial_reg <= 1'h0;
    end else begin
      partial_reg <= partial_next;
    end
  end

  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      size_reg <= `ZERO16;
    end else if (capture) begin
      size_reg <= i_segment_bytes; // [RULE9]
    end
  end

  // ****************************************
  // edge result words: left, top, right, bottom
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < EDGE_COUNT; g = g + 1) begin : g_edge
      eye_edge_store u_store (
        .i_clk(i_clk),
        .i_arst_n(i_arst_n),
        .i_load(capture),
        .i_voltage_code(i_voltage_codes[g*CODE_W +: CODE_W]),
        .i_phase_code(i_phase_codes[g*CODE_W +: CODE_W]),
        .o_word(edge_words[g*WORD_W +: WORD_W])
      ); // [RULE3]
    end
  endgenerate

  // ****************************************
  // read decode
  // ****************************************
  // one shared selector instead of a mux leg per edge word
  always @* begin
    edge_sel = edge_words[edge_slot(i_rd_addr)*WORD_W +: WORD_W]; // [RULE3]
  end

  always @* begin
    rd_next = `ZERO16; // [RULE11]
    if (i_rd_addr == `ADDR_SCAN_SIZE) begin
      rd_next = size_reg; // [RULE9]
    end else if (is_edge_addr(i_rd_addr)) begin
      rd_next = edge_sel; // [RULE1] [RULE2] [RULE3]
    end else if (i_rd_addr == `ADDR_STATE) begin
      rd_next = status_word(partial_reg, state_reg); // [RULE4] [RULE6]
    end
  end

  // all registers read-only; no write path exists, so writes cannot land [RULE11]
  // read data holds between strobes, so a slow host may sample it late
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rd_data <= `ZERO16;
    end else if (i_rd_en) begin
      o_rd_data <= rd_next;
    end
  end

endmodule // eye_monitor_result_status_regs

// ---- include/eye_monitor_defines.vh ----
// Functional notes
// RULE1: voltage code 0 low, 127 zero, 255 high
// RULE2: phase code clamped to 0 through 127
// RULE3: voltage bits 15:8, phase 7:0, four words
// RULE4: status bit 8 full/partial on plain scan
// RULE5: bit 8 undefined after shape scan
// RULE6: state field bits 1:0, four codes
// RULE7: start and state form four-way handshake
// RULE8: lock loss or sleep gives abort code
// RULE9: 16-bit partial segment byte size readable
// RULE10: start, busy, done/abort, start low, idle
// RULE11: reserved bits and addresses read zero
`ifndef EYE_MONITOR_DEFINES_VH
`define EYE_MONITOR_DEFINES_VH

// ****************************************
// register offsets (word addresses)
// ****************************************
`define ADDR_SCAN_SIZE 8'h8b
`define ADDR_LEFT_EDGE 8'h8c
`define ADDR_TOP_EDGE 8'h8d
`define ADDR_RIGHT_EDGE 8'h8e
`define ADDR_BOTTOM_EDGE 8'h8f
`define ADDR_STATE 8'h90

// ****************************************
// monitor state codes
// ****************************************
`define ST_IDLE 2'h0
`define ST_BUSY 2'h1
`define ST_DONE 2'h2
`define ST_ABORT 2'h3

// ****************************************
// fields and limits
// ****************************************
`define PARTIAL_BIT 8
`define PHASE_MAX 8'h7f
`define ZERO16 16'h0000
`define ZERO8 8'h00
`define STATE_MSB 1
`define STATE_LSB 0

// ****************************************
// default widths and counts
// ****************************************
`define CODE_BITS 8
`define WORD_BITS 16
`define EDGE_WORDS 4
`define ADDR_BITS 8

`endif

// ---- verilog/eye_edge_store.v ----
`timescale 1ns/1ps
`include "eye_monitor_defines.vh"

// holds one edge result word; phase clamped on capture
module eye_edge_store (
  // clock and reset
  input wire i_clk,
  input wire i_arst_n,
  // capture
  input wire i_load,
  input wire [7:0] i_voltage_code,
  input wire [7:0] i_phase_code,
  // result
  output reg [15:0] o_word
);

  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_word <= `ZERO16;
    end else if (i_load) begin
      o_word[15:8] <= i_voltage_code; // [RULE1] [RULE3]
      o_word[7:0] <= (i_phase_code > `PHASE_MAX) ? `PHASE_MAX : i_phase_code; // [RULE2] [RULE3]
    end
  end

endmodule // eye_edge_store

// ---- verification/eye_regs_sva.sv ----
`timescale 1ns/1ps
module eye_regs_sva(input wire i_clk,input wire i_arst_n,input wire i_scan_done,
  input wire i_monitor_start_request,input wire i_cdr_locked,input wire i_sleep,
  input wire o_engine_run,input wire [1:0] o_monitor_state_field);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  wire [1:0] s=o_monitor_state_field;
  wire g=i_monitor_start_request;
  wire f=!i_cdr_locked||i_sleep;
  wire b=s==2'h1;
  a_go_busy: assert property (s==2'h0&&g&&!f |=> b) else $error("busy");
  a_go_abort: assert property (s==2'h0&&g&&f |=> s==2'h3) else $error("abort");
  a_fault_abort: assert property (b&&f |=> s==2'h3) else $error("fault");
  a_done_ok: assert property (b&&i_scan_done&&!f |=> s==2'h2) else $error("done");
  a_end_hold: assert property (s[1]&&g |=> $stable(s)) else $error("hold");
  a_end_idle: assert property (s[1]&&!g |=> s==2'h0) else $error("idle");
  a_run_busy: assert property (o_engine_run==b) else $error("run");
  a_idle_wait: assert property (s==2'h0&&!g |=> s==2'h0) else $error("wait");
endmodule // eye_regs_sva
bind eye_monitor_result_status_regs eye_regs_sva chk(.*);

// ---- verification/host_model.sv ----
`timescale 1ns/1ps
module host_model(input wire i_clk,input wire i_go,input wire [1:0] i_state,
  output reg o_start);
  initial o_start=1'b0;
  // start only from idle; held until done/abort is seen and the bench lets go
  always @(posedge i_clk)
    o_start<=o_start?!(i_state[1]&&!i_go):i_go&&i_state==2'h0;
endmodule // host_model

// ---- verification/testbench.sv ----
`timescale 1ns/1ps
module testbench;
  reg i_clk=0,i_arst_n=0,i_rd_en=0,i_shape_scan_select=0,i_scan_done=0,i_scan_partial=0;
  reg i_cdr_locked=1,i_sleep=0,go=0;
  reg [7:0] i_rd_addr=8'h00;
  reg [15:0] i_segment_bytes=16'h0000;
  reg [31:0] i_voltage_codes=32'h0000_0000,i_phase_codes=32'h0000_0000,r;
  wire [15:0] o_rd_data;
  wire [1:0] s;
  wire o_engine_run,i_monitor_start_request;
  integer errors=0,checked=0,k,a,cyc=0;
  always #5 i_clk=~i_clk;
  eye_monitor_result_status_regs uut(.i_clk(i_clk),.i_arst_n(i_arst_n),.i_rd_en(i_rd_en),
    .i_rd_addr(i_rd_addr),.o_rd_data(o_rd_data),
    .i_monitor_start_request(i_monitor_start_request),
    .i_shape_scan_select(i_shape_scan_select),.i_scan_done(i_scan_done),
    .i_scan_partial(i_scan_partial),.i_voltage_codes(i_voltage_codes),
    .i_phase_codes(i_phase_codes),.i_segment_bytes(i_segment_bytes),
    .i_cdr_locked(i_cdr_locked),.i_sleep(i_sleep),.o_engine_run(o_engine_run),
    .o_monitor_state_field(s));
  host_model hm(.i_clk(i_clk),.i_go(go),.i_state(s),.o_start(i_monitor_start_request));
  task chk_word(input [39:0] n,input [15:0] e,input [15:0] g);
    begin
      checked=checked+1;
      if(g!==e) begin
        errors=errors+1;
        $display("BAD %s exp %h got %h",n,e,g);
      end
    end
  endtask
  task chk_state(input [1:0] e,input x);
    begin
      checked=checked+2;
      if(s!==e) begin
        errors=errors+1;
        $display("BAD state exp %h got %h",e,s);
      end
      if(o_engine_run!==x) begin
        errors=errors+1;
        $display("BAD run exp %h got %h",x,o_engine_run);
      end
    end
  endtask
  // expected read word for offset i from the size register
  function [15:0] exp_word(input integer i);
    begin
      if(i==0) exp_word=i_segment_bytes;
      else if(i==5) exp_word={7'h00,i_scan_partial&~i_shape_scan_select,8'h00};
      else if(i==6) exp_word=16'h0000;
      else exp_word={i_voltage_codes[i*8-8+:8],
        i_phase_codes[i*8-1]?8'h7f:i_phase_codes[i*8-8+:8]};
    end
  endfunction
  task report_and_stop;
    begin
      $display("checked %0d errors %0d",checked,errors);
      if(errors==0&&checked>0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  always @(posedge i_clk) begin
    cyc=cyc+1;
    if(cyc==2000) begin
      errors=errors+1;
      report_and_stop;
    end
  end
  initial begin
    k=$urandom(42);
    @(posedge i_clk);
    #1 chk_state(2'h0,1'h0);
    chk_word("reset",16'h0000,o_rd_data);
    repeat(3) @(posedge i_clk);
    i_arst_n<=1;
    for(k=0;k<9;k=k+1) begin
      @(posedge i_clk) go<=1;
      r=$urandom;
      i_cdr_locked<=k%3!=1;
      i_voltage_codes<=$urandom;
      i_phase_codes<=k?$urandom:32'hff80_7f00;
      {i_scan_partial,i_shape_scan_select}<=r[1:0];
      i_segment_bytes<=r[31:16];
      repeat(3) @(posedge i_clk);
      i_scan_done<=k%3==0;
      // sleep on runs 2 and 8, lock loss during the scan on run 5
      i_sleep<=k%3==2&&!k[0];
      i_cdr_locked<=!(k%3==2&&k[0]);
      #1 chk_state(k%3==1?2'h3:2'h1,k%3!=1);
      @(posedge i_clk) i_scan_done<=0;
      i_sleep<=0;
      i_cdr_locked<=1;
      #1 chk_state(k%3?2'h3:2'h2,1'h0);
      @(posedge i_clk) go<=0;
      repeat(3) @(posedge i_clk);
      #1 chk_state(2'h0,1'h0);
      if(k%3==0) for(a=0;a<7;a=a+1) begin
        @(posedge i_clk) i_rd_en<=1;
        i_rd_addr<=8'h8b+a[7:0];
        @(posedge i_clk) i_rd_en<=0;
        #1 chk_word("read",exp_word(a),o_rd_data);
      end
      $display("test %0d done",k);
    end
    report_and_stop;
  end
endmodule // testbench
